// file: design/dbsp_async_fifo.sv
// dual clock fifo with gray coded pointers, valid and ready on both sides
// assumes each side has a synchronous active high reset in its own domain
`timescale 1ns/1ps
module dbsp_async_fifo
    import dbsp_pkg::*;
#(
    parameter int W = 8,                   // word width
    parameter int DEPTH = FIFO_DEPTH_DEF   // words, a power of two
) (
    input wire logic wclk,
    input wire logic wrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    input wire logic rclk,
    input wire logic rrst,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH); // index bits

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [W-1:0] mem [DEPTH]; // word store
    logic [AW:0] wbin_q;       // write pointer, binary
    logic [AW:0] wgray_q;      // write pointer, gray
    logic [AW:0] rbin_q;       // read pointer, binary
    logic [AW:0] rgray_q;      // read pointer, gray
    logic [AW:0] rgray_w;      // read pointer seen by the writer
    logic [AW:0] wgray_r;      // write pointer seen by the reader
    logic [AW:0] wbin_d;       // next write pointer
    logic [AW:0] rbin_d;       // next read pointer

    assign wbin_d = wbin_q + {{AW{1'b0}}, 1'b1};
    assign rbin_d = rbin_q + {{AW{1'b0}}, 1'b1};

    // full when the writer is one lap ahead
    assign in_ready = (wgray_q != {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
    // empty when the pointers meet
    assign out_valid = (rgray_q != wgray_r);
    assign out_data = mem[rbin_q[AW-1:0]];

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    always_ff @(posedge wclk) begin
        if (in_valid && in_ready) begin
            mem[wbin_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            wbin_q <= '0;
            wgray_q <= '0;
        end else if (in_valid && in_ready) begin
            wbin_q <= wbin_d;
            wgray_q <= wbin_d ^ (wbin_d >> 1);
        end
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    always_ff @(posedge rclk) begin
        if (rrst) begin
            rbin_q <= '0;
            rgray_q <= '0;
        end else if (out_valid && out_ready) begin
            rbin_q <= rbin_d;
            rgray_q <= rbin_d ^ (rbin_d >> 1);
        end
    end

    // ------------------------------------------------------------
    // pointer crossings
    // ------------------------------------------------------------
    dbsp_sync #(.W(AW + 1)) u_rptr_sync (
        .clk(wclk),
        .d(rgray_q),
        .q(rgray_w)
    );

    dbsp_sync #(.W(AW + 1)) u_wptr_sync (
        .clk(rclk),
        .d(wgray_q),
        .q(wgray_r)
    );

endmodule // dbsp_async_fifo

// file: design/dbsp_pkg.sv
// constants shared by the burst sram port, its fifo and its synchronisers
// assumes a 20 MHz core clock and an input clock pair from the memory controller
package dbsp_pkg;

    // ------------------------------------------------------------
    // data organisation
    // ------------------------------------------------------------
    localparam int LANE_W = 9;          // bits gated by one byte lane enable
    localparam int DATA_W_DEF = 18;     // narrow configuration word width
    localparam int ADDR_W_DEF = 19;     // address width of the narrow configuration
    localparam int FIFO_DEPTH_DEF = 16; // write words buffered toward the core

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 50;  // core clock period
    localparam int RD_LAT_PLL_HALF = 3;  // first read word, half cycles, pll on
    localparam int RD_LAT_BYP_HALF = 2;  // first read word, half cycles, pll bypassed
    localparam int SYNC_STAGES = 2;      // flops in every level synchroniser

    // ------------------------------------------------------------
    // core drain states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DBSP_DRN_IDLE = 2'b00,  // waiting for a buffered write
        DBSP_DRN_LO = 2'b01,    // storing the first burst word
        DBSP_DRN_HI = 2'b10     // storing the second burst word
    } dbsp_drain_e;

    localparam dbsp_drain_e DRN_RESET = DBSP_DRN_IDLE; // state after reset

endpackage

// file: design/dbsp_port.sv
// double data rate burst sram port: input clock capture, core array, output launch
// assumes the controller drives input and output clocks of one frequency,
// with the negative clock of each pair the inverse of the positive one
`timescale 1ns/1ps
module dbsp_port
    import dbsp_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF,        // 18 or 36
    parameter int ADDR_W = ADDR_W_DEF,        // 19 or 18
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF // buffered writes
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic k_clk,
    input wire logic c_clk,
    input wire logic single_clk_mode,
    input wire logic pll_bypass_n,
    input wire logic [ADDR_W-1:0] addr_bus,
    input wire logic wr_port_sel_n,
    input wire logic rd_port_sel_n,
    input wire logic [DATA_W-1:0] wr_bus_in,
    input wire logic [DATA_W/LANE_W-1:0] byte_lane_en_n,
    output logic wr_ready,
    output logic [DATA_W-1:0] rd_bus_out,
    output logic rd_bus_oe,
    output logic echo_timing_pos,
    output logic echo_timing_neg
);

    localparam int NL = DATA_W / LANE_W;       // byte lanes
    localparam int FW = ADDR_W + 2 * (DATA_W + NL); // buffered write word

    // ------------------------------------------------------------
    // clocks and straps
    // ------------------------------------------------------------
    logic oclk;     // output launch clock
    logic k_rst;    // reset in the input clock domain
    logic pll_on_o; // pll enabled, seen in the output domain

    // strap is static, so a plain mux is glitch free in use
    assign oclk = single_clk_mode ? k_clk : c_clk;
    // echo pair is the launch clock itself, never gated
    assign echo_timing_pos = oclk;
    assign echo_timing_neg = ~oclk;

    dbsp_sync #(.W(1)) u_rst_sync (
        .clk(k_clk),
        .d(rst),
        .q(k_rst)
    );

    dbsp_sync #(.W(1)) u_pll_sync (
        .clk(oclk),
        .d(pll_bypass_n),
        .q(pll_on_o)
    );

    // ------------------------------------------------------------
    // core array, two halves of one burst each
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem_lo [2**ADDR_W]; // first burst words
    logic [DATA_W-1:0] mem_hi [2**ADDR_W]; // second burst words

    // ------------------------------------------------------------
    // write capture, input clock domain
    // ------------------------------------------------------------
    logic wr_act_q;                 // write sampled at the last rise
    logic [DATA_W-1:0] wr_d0_q;     // first write word
    logic [NL-1:0] wr_m0_q;         // first word lane enables
    logic [DATA_W-1:0] wr_d1_q;     // second write word
    logic [NL-1:0] wr_m1_q;         // second word lane enables
    logic [ADDR_W-1:0] wr_addr_q;   // write address
    logic [FW-1:0] fifo_in;         // packed write
    logic [FW-1:0] fifo_out;        // packed write at the core
    logic fifo_valid;               // core has a write waiting
    logic fifo_take;                // core accepts it

    // write select on the positive clock rise
    always_ff @(posedge k_clk) begin
        if (k_rst) begin
            wr_act_q <= 1'b0;
        end else begin
            wr_act_q <= ~wr_port_sel_n;
        end
    end

    // first word and its enables share the select edge
    always_ff @(posedge k_clk) begin
        if (!wr_port_sel_n) begin
            wr_d0_q <= wr_bus_in;
            wr_m0_q <= byte_lane_en_n;
        end
    end

    // second word, enables and address on the negative clock rise
    always_ff @(negedge k_clk) begin
        if (wr_act_q) begin
            wr_d1_q <= wr_bus_in;
            wr_m1_q <= byte_lane_en_n;
            wr_addr_q <= addr_bus;
        end
    end

    logic fifo_ready_k; // buffer has room

    // write leaves for the core at the next rise; a full buffer drops it
    assign fifo_in = {wr_addr_q, wr_m1_q, wr_d1_q, wr_m0_q, wr_d0_q};
    assign wr_ready = fifo_ready_k;

    dbsp_async_fifo #(.W(FW), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .wclk(k_clk),
        .wrst(k_rst),
        .in_valid(wr_act_q),
        .in_ready(fifo_ready_k),
        .in_data(fifo_in),
        .rclk(mclk),
        .rrst(rst),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_out)
    );

    // ------------------------------------------------------------
    // core drain, one half per core cycle
    // ------------------------------------------------------------
    dbsp_drain_e drn_q;       // drain state
    logic [FW-1:0] hold_q;    // write being stored
    logic [ADDR_W-1:0] h_addr; // its address
    logic [NL-1:0] h_m0;      // first word enables
    logic [NL-1:0] h_m1;      // second word enables
    logic [DATA_W-1:0] h_d0;  // first word
    logic [DATA_W-1:0] h_d1;  // second word

    assign {h_addr, h_m1, h_d1, h_m0, h_d0} = hold_q;
    // the drain stalls the buffer while a burst is being stored
    assign fifo_take = (drn_q == DBSP_DRN_IDLE);

    always_ff @(posedge mclk) begin
        if (rst) begin
            drn_q <= DRN_RESET;
        end else begin
            case (drn_q)
                DBSP_DRN_IDLE: begin
                    if (fifo_valid) begin
                        drn_q <= DBSP_DRN_LO;
                    end
                end
                DBSP_DRN_LO: begin
                    drn_q <= DBSP_DRN_HI;
                end
                DBSP_DRN_HI: begin
                    drn_q <= DBSP_DRN_IDLE;
                end
                default: begin
                    drn_q <= DRN_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (fifo_take && fifo_valid) begin
            hold_q <= fifo_out;
        end
    end

    // lane by lane, a masked lane keeps its old contents
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NL; i++) begin
            if (drn_q == DBSP_DRN_LO && !h_m0[i]) begin
                mem_lo[h_addr][i*LANE_W +: LANE_W] <= h_d0[i*LANE_W +: LANE_W];
            end
            if (drn_q == DBSP_DRN_HI && !h_m1[i]) begin
                mem_hi[h_addr][i*LANE_W +: LANE_W] <= h_d1[i*LANE_W +: LANE_W];
            end
        end
    end

    // ------------------------------------------------------------
    // read capture, input clock domain
    // ------------------------------------------------------------
    logic rd_go_q;             // read sampled at the last rise
    logic [DATA_W-1:0] rd_w0_q; // first burst word
    logic [DATA_W-1:0] rd_w1_q; // second burst word

    always_ff @(posedge k_clk) begin
        if (k_rst) begin
            rd_go_q <= 1'b0;
        end else begin
            rd_go_q <= ~rd_port_sel_n;
        end
    end

    // a read landing on a write still in the buffer sees the old data
    always_ff @(posedge k_clk) begin
        if (!rd_port_sel_n) begin
            rd_w0_q <= mem_lo[addr_bus];
            rd_w1_q <= mem_hi[addr_bus];
        end
    end

    // ------------------------------------------------------------
    // read launch, output clock domain
    // ------------------------------------------------------------
    logic go_d_q;               // read one output cycle old
    logic [DATA_W-1:0] ow0_q;   // first word held for the fall
    logic [DATA_W-1:0] ow1_q;   // second word held for the rise, or for the fall with the pll bypassed
    logic [DATA_W-1:0] q_pos_q; // word launched at the rise
    logic [DATA_W-1:0] q_neg_q; // word launched at the fall
    logic oe_pos_q;             // drive during the high phase
    logic oe_neg_q;             // drive during the low phase

    // output clock shares the input clock frequency, so the read
    // flags are taken directly; the controller owns the skew
    always_ff @(posedge oclk) begin
        if (k_rst) begin
            go_d_q <= 1'b0;
            oe_pos_q <= 1'b0;
        end else begin
            go_d_q <= rd_go_q;
            // pending burst finishes, then the rise turns drive off
            oe_pos_q <= pll_on_o ? go_d_q : rd_go_q;
        end
    end

    always_ff @(posedge oclk) begin
        ow0_q <= rd_w0_q;
        ow1_q <= rd_w1_q;
        if (pll_on_o && go_d_q) begin
            q_pos_q <= ow1_q;
        end else if (!pll_on_o && rd_go_q) begin
            q_pos_q <= rd_w0_q;
        end
    end

    always_ff @(negedge oclk) begin
        if (k_rst) begin
            oe_neg_q <= 1'b0;
        end else begin
            oe_neg_q <= go_d_q;
        end
    end

    always_ff @(negedge oclk) begin
        if (go_d_q) begin
            q_neg_q <= pll_on_o ? ow0_q : ow1_q;
        end
    end

    // phase selects which launch register is on the pins
    assign rd_bus_out = oclk ? q_pos_q : q_neg_q;
    assign rd_bus_oe = oclk ? oe_pos_q : oe_neg_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_WR_START: assert property (@(posedge k_clk) disable iff (k_rst)
        !wr_port_sel_n |=> wr_act_q && wr_d0_q == $past(wr_bus_in))
        else $error("write select low did not capture first word");

    AST_WR_IGNORE: assert property (@(posedge k_clk) disable iff (k_rst)
        wr_port_sel_n |=> !wr_act_q && $stable(wr_d0_q))
        else $error("deselected write port changed state");

    AST_RD_START: assert property (@(posedge k_clk) disable iff (k_rst)
        !rd_port_sel_n |=> rd_go_q)
        else $error("read select low did not start a read");

    AST_RD_ADDR_IGNORE: assert property (@(posedge k_clk) disable iff (k_rst)
        rd_port_sel_n |=> $stable(rd_w0_q) && $stable(rd_w1_q))
        else $error("deselected read port accessed the array");

    AST_PLL_LATENCY: assert property (@(posedge oclk) disable iff (k_rst)
        rd_go_q && pll_on_o |=> (oe_neg_q && q_neg_q == $past(rd_w0_q))
        ##1 (oe_pos_q && q_pos_q == $past(rd_w1_q, 2)))
        else $error("pll read words out of place");

    AST_BYP_LATENCY: assert property (@(posedge oclk) disable iff (k_rst)
        rd_go_q && !pll_on_o |=> oe_pos_q && oe_neg_q && q_pos_q == $past(rd_w0_q)
        && q_neg_q == $past(rd_w1_q))
        else $error("bypass read words out of place");

    AST_TRISTATE: assert property (@(posedge oclk) disable iff (k_rst)
        !rd_go_q && !go_d_q |=> !oe_pos_q)
        else $error("read bus driven with no pending read");

    AST_LANE_STORE: assert property (@(posedge mclk) disable iff (rst)
        drn_q == DBSP_DRN_LO && !h_m0[0]
        |=> mem_lo[$past(h_addr)][LANE_W-1:0] == $past(h_d0[LANE_W-1:0]))
        else $error("enabled lane not stored");

    AST_HALVES: assert property (@(posedge mclk) disable iff (rst)
        drn_q == DBSP_DRN_LO |=> drn_q == DBSP_DRN_HI ##1 drn_q == DBSP_DRN_IDLE)
        else $error("burst halves not stored in order");

    COV_WRITE: cover property (@(posedge k_clk) disable iff (k_rst)
        !wr_port_sel_n && fifo_ready_k);
    COV_READ_PLL: cover property (@(posedge oclk) disable iff (k_rst)
        rd_go_q && pll_on_o ##2 oe_pos_q);
    COV_FULL: cover property (@(posedge k_clk) disable iff (k_rst)
        !fifo_ready_k);

endmodule // dbsp_port

// file: design/dbsp_sync.sv
// level synchroniser: a chain of flops into the destination clock
// assumes the input is a slow level or a gray coded value
`timescale 1ns/1ps
module dbsp_sync
    import dbsp_pkg::*;
#(
    parameter int W = 1  // bits carried side by side
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    // ------------------------------------------------------------
    // two stage chain
    // ------------------------------------------------------------
    logic [W-1:0] meta_q; // first stage, read only by the second

    // no reset: a reset here would itself need synchronising
    always_ff @(posedge clk) begin
        meta_q <= d;
        q <= meta_q;
    end

endmodule // dbsp_sync

// file: tb/dbsp_ctrl_model.sv
// controller model: drives address, port selects, write data and lane enables
// assumes k_clk comes from the bench; the caller keeps one read and one write per cycle
`timescale 1ns/1ps
module dbsp_ctrl_model
    import dbsp_pkg::*;
#(
    parameter int DW = DATA_W_DEF,  // data width
    parameter int AW = ADDR_W_DEF   // address width
) (
    input wire logic k_clk,
    output logic [AW-1:0] addr_bus,
    output logic wr_port_sel_n,
    output logic rd_port_sel_n,
    output logic [DW-1:0] wr_bus_in,
    output logic [DW/LANE_W-1:0] byte_lane_en_n
);
    // ------------------------------------------------------------
    // idle levels
    // ------------------------------------------------------------
    initial begin
        addr_bus = '0;
        wr_bus_in = '0;
        byte_lane_en_n = '1;
        wr_port_sel_n = 1'b1;
        rd_port_sel_n = 1'b1;
    end

    // one cycle: first half set up for the rise, second half for the fall
    // values change 7 ns after an edge so that both edges see settled pins
    task automatic xfer(input logic rd, input logic wr, input logic [AW-1:0] ra,
                        input logic [AW-1:0] wa, input logic [DW-1:0] w0,
                        input logic [DW-1:0] w1, input logic [DW/LANE_W-1:0] e0,
                        input logic [DW/LANE_W-1:0] e1);
        @(negedge k_clk);
        #7;
        rd_port_sel_n = ~rd;
        wr_port_sel_n = ~wr;
        addr_bus = ra;
        wr_bus_in = w0;
        byte_lane_en_n = e0;
        @(posedge k_clk);
        #7;
        // selects drop after one rise: at most one read and one write a cycle
        rd_port_sel_n = 1'b1;
        wr_port_sel_n = 1'b1;
        addr_bus = wa;
        wr_bus_in = w1;
        byte_lane_en_n = e1;
    endtask
endmodule // dbsp_ctrl_model

// file: tb/ddr_burst_sram_port_bench.sv
// self-checking bench of the burst sram port: writes, lane masks, reads in both latencies
// assumes the design package and the controller model are compiled first
`timescale 1ns/1ps
module ddr_burst_sram_port_bench;
    import dbsp_pkg::*;
    localparam int DW = DATA_W_DEF;
    localparam int AW = ADDR_W_DEF;
    localparam int NL = DW / LANE_W;
    typedef struct {int hc; logic [DW-1:0] w0; logic [DW-1:0] w1;} dbsp_exp_s;
    logic mclk, rst, k_clk, c_clk, single_clk_mode, pll_bypass_n;
    logic [AW-1:0] addr_bus;
    logic wr_port_sel_n, rd_port_sel_n, wr_ready, rd_bus_oe, echo_timing_pos, echo_timing_neg;
    logic [DW-1:0] wr_bus_in, rd_bus_out;
    logic [NL-1:0] byte_lane_en_n;
    logic [DW-1:0] mem_lo [int];  // expected first halves
    logic [DW-1:0] mem_hi [int];  // expected second halves
    dbsp_exp_s exp_q [$];         // reads in flight
    int miscompares = 0;
    int tests_run = 0;
    int hc = 0;                   // half cycles of k_clk
    int widx = 0;                 // burst word expected next
    int lat = RD_LAT_PLL_HALF;
    logic [31:0] seed = 32'h55C55B78;
    logic live = 1'b0;
    logic saw_full = 1'b0;

    // ------------------------------------------------------------
    // clocks; output clock in phase with the input clock outside single clock mode
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        k_clk = 1'b0;
        #7;
        forever #15 k_clk = ~k_clk;
    end
    // output clock stops in single clock mode, so a launch still tied to it shows up
    assign c_clk = k_clk & ~single_clk_mode;

    dbsp_port dbsp_port_i (.mclk(mclk), .rst(rst), .k_clk(k_clk), .c_clk(c_clk),
        .single_clk_mode(single_clk_mode), .pll_bypass_n(pll_bypass_n), .addr_bus(addr_bus),
        .wr_port_sel_n(wr_port_sel_n), .rd_port_sel_n(rd_port_sel_n), .wr_bus_in(wr_bus_in),
        .byte_lane_en_n(byte_lane_en_n), .wr_ready(wr_ready), .rd_bus_out(rd_bus_out),
        .rd_bus_oe(rd_bus_oe), .echo_timing_pos(echo_timing_pos),
        .echo_timing_neg(echo_timing_neg));
    dbsp_ctrl_model #(.DW(DW), .AW(AW)) dbsp_ctrl_model_i (.k_clk(k_clk), .addr_bus(addr_bus),
        .wr_port_sel_n(wr_port_sel_n), .rd_port_sel_n(rd_port_sel_n), .wr_bus_in(wr_bus_in),
        .byte_lane_en_n(byte_lane_en_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic cmp_data(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // lanes with a low enable take the new word, the others keep old contents
    function automatic void merge(int a, logic [DW-1:0] w0, logic [DW-1:0] w1,
                                  logic [NL-1:0] e0, logic [NL-1:0] e1);
        for (int i = 0; i < NL; i++) begin
            if (!e0[i]) mem_lo[a][i*LANE_W +: LANE_W] = w0[i*LANE_W +: LANE_W];
            if (!e1[i]) mem_hi[a][i*LANE_W +: LANE_W] = w1[i*LANE_W +: LANE_W];
        end
    endfunction

    // one cycle of traffic; a write counts only if there was room at its push rise
    task automatic op(input logic rd, input logic wr, input int ra, input int wa,
                      input logic [NL-1:0] e0, input logic [NL-1:0] e1);
        logic [DW-1:0] w0;
        logic [DW-1:0] w1;
        dbsp_exp_s e;
        w0 = DW'(lfsr_next());
        w1 = DW'(lfsr_next());
        for (int n = 0; wr && n < 400 && wr_ready !== 1'b1; n++) @(negedge k_clk);
        dbsp_ctrl_model_i.xfer(rd, wr, AW'(ra), AW'(wa), w0, w1, e0, e1);
        if (rd) begin
            e.hc = hc + lat;
            e.w0 = mem_lo[ra];
            e.w1 = mem_hi[ra];
            exp_q.push_back(e);
        end
        fork
            begin
                @(negedge k_clk);
                #2;
                if (wr && wr_ready === 1'b1) merge(wa, w0, w1, e0, e1);
            end
        join_none
    endtask

    task automatic drain();
        repeat (200) @(posedge k_clk);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // output watcher: echo clocks, drive enable and burst words
    // ------------------------------------------------------------
    always @(k_clk) begin
        hc++;
        #9;
        if (live) begin
            cmp_bit(echo_timing_pos, k_clk);
            cmp_bit(echo_timing_neg, ~k_clk);
            if (wr_ready === 1'b0) saw_full = 1'b1;
            if (widx == 1 || (exp_q.size() > 0 && hc >= exp_q[0].hc)) begin
                cmp_bit(rd_bus_oe, 1'b1);
                if (widx == 0) begin
                    cmp_data(rd_bus_out, exp_q[0].w0);
                    widx = 1;
                end else begin
                    cmp_data(rd_bus_out, exp_q[0].w1);
                    void'(exp_q.pop_front());
                    widx = 0;
                end
            end else begin
                cmp_bit(rd_bus_oe, 1'b0);
            end
        end
    end

    // hang guard
    initial begin
        #200000;
        miscompares++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        single_clk_mode = 1'b0;
        pll_bypass_n = 1'b1;
        repeat (4) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        repeat (4) @(posedge k_clk);
        live = 1'b1;
        // back to back full writes until the buffer refuses
        for (int i = 0; i < 24; i++) op(1'b0, 1'b1, 0, i, '0, '0);
        drain();
        // every lane mask pattern on both words, then a deselected write
        for (int i = 0; i < 16; i++) begin
            if (mem_lo.exists(i)) op(1'b0, 1'b1, 0, i, NL'(i), NL'(i >> 2));
        end
        op(1'b0, 1'b0, 0, 1, '0, '0);
        drain();
        // back to back reads, one with a concurrent write
        for (int i = 0; i < 24; i++) begin
            if (mem_lo.exists(i)) op(1'b1, i == 5, i, 40, '0, '0);
        end
        drain();
        if (mem_lo.exists(40)) op(1'b1, 1'b0, 40, 0, '0, '0);
        repeat (10) @(posedge k_clk);
        // bypassed pll, single clock mode, random addresses
        @(negedge mclk);
        pll_bypass_n = 1'b0;
        single_clk_mode = 1'b1;
        lat = RD_LAT_BYP_HALF;
        repeat (8) @(posedge k_clk);
        for (int i = 0; i < 12; i++) begin
            int a;
            a = int'(lfsr_next() % 24);
            if (mem_lo.exists(a)) op(1'b1, 1'b0, a, 0, '0, '0);
        end
        repeat (10) @(posedge k_clk);
        cmp_bit(exp_q.size() == 0, 1'b1);
        cmp_bit(saw_full, 1'b1);
        conclude();
    end
endmodule // ddr_burst_sram_port_bench
